/* common/hwmtx_pkg.sv */
// Package: register map, field layout and bus carrier types of the hardware lock
package hwmtx_pkg;

  // ----------------------------------------------------------------
  // Register indices (word offsets on the agent port)
  // ----------------------------------------------------------------
  localparam logic [0:0] LOCK_STATE_IDX = 1'h0;
  localparam logic [0:0] RESET_INDICATOR_IDX = 1'h1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OWNER_MSB = 31;
  localparam int OWNER_LSB = 16;
  localparam int VALUE_MSB = 15;
  localparam int VALUE_LSB = 0;
  localparam int RESET_FLAG_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] VALUE_FREE = 16'h0000;
  localparam logic RESET_FLAG_INIT = 1'h1;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] owner;
    logic [15:0] value;
  } hwmtx_lock_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [0:0] address;
    logic [31:0] writedata;
  } hwmtx_req_type;

endpackage

/* logic/hwmtx_core.sv */
// Hardware lock: atomic test-and-set register with reset indicator flag
`timescale 1ns/1ps
`default_nettype none

module hwmtx_core #(
  parameter logic [15:0] INIT_VALUE = 16'h0000,
  parameter logic [15:0] INIT_OWNER = 16'h0000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Agent port
  input wire logic [0:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  // Status
  output logic lock_held
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  hwmtx_pkg::hwmtx_req_type req;
  hwmtx_pkg::hwmtx_lock_type lock_r, lock_nxt, wr_lock;
  logic reset_flag_r, reset_flag_nxt;
  logic [31:0] readdata_r, readdata_nxt;
  logic lock_held_r, lock_held_nxt;
  logic may_write;

  assign req = '{read: read, write: write, address: address, writedata: writedata};
  assign wr_lock = hwmtx_pkg::hwmtx_lock_type'(req.writedata);

  function automatic logic is_free(input hwmtx_pkg::hwmtx_lock_type l);
    return l.value == hwmtx_pkg::VALUE_FREE;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    // Test and set happen in one cycle, so back-to-back writes resolve in bus order
    may_write = is_free(lock_r) || (lock_r.owner == wr_lock.owner);
    lock_nxt = lock_r;
    reset_flag_nxt = reset_flag_r;
    readdata_nxt = readdata_r;
    if (req.write && req.address == hwmtx_pkg::LOCK_STATE_IDX && may_write) begin
      lock_nxt = wr_lock;
    end
    if (req.write && req.address == hwmtx_pkg::RESET_INDICATOR_IDX &&
        req.writedata[hwmtx_pkg::RESET_FLAG_BIT]) begin
      reset_flag_nxt = 1'b0;
    end
    if (req.read) begin
      unique case (req.address)
        hwmtx_pkg::LOCK_STATE_IDX: readdata_nxt = lock_r;
        hwmtx_pkg::RESET_INDICATOR_IDX: begin
          readdata_nxt = hwmtx_pkg::READ_ZERO;
          readdata_nxt[hwmtx_pkg::RESET_FLAG_BIT] = reset_flag_r;
        end
      endcase
    end
    lock_held_nxt = !is_free(lock_nxt);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lock_r <= '{owner: INIT_OWNER, value: INIT_VALUE};
      reset_flag_r <= hwmtx_pkg::RESET_FLAG_INIT;
      readdata_r <= hwmtx_pkg::READ_ZERO;
      lock_held_r <= (INIT_VALUE != hwmtx_pkg::VALUE_FREE);
    end else begin
      lock_r <= lock_nxt;
      reset_flag_r <= reset_flag_nxt;
      readdata_r <= readdata_nxt;
      lock_held_r <= lock_held_nxt;
    end
  end

  assign readdata = readdata_r;
  assign lock_held = lock_held_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  refused_write_a: assert property (@(posedge ref_clk) disable iff (srst)
    (write && address == hwmtx_pkg::LOCK_STATE_IDX && lock_r.value != 16'h0000 &&
     lock_r.owner != writedata[31:16]) |=> $stable(lock_r))
    else $error("refused lock write changed the register");
  taken_write_a: assert property (@(posedge ref_clk) disable iff (srst)
    (write && address == hwmtx_pkg::LOCK_STATE_IDX && lock_r.value == 16'h0000)
    |=> lock_r == $past(writedata))
    else $error("write to free lock not applied next cycle");
  owner_write_a: assert property (@(posedge ref_clk) disable iff (srst)
    (write && address == hwmtx_pkg::LOCK_STATE_IDX && lock_r.owner == writedata[31:16])
    |=> lock_r == $past(writedata))
    else $error("holder write not applied");
  lock_read_a: assert property (@(posedge ref_clk) disable iff (srst)
    (read && !write && address == hwmtx_pkg::LOCK_STATE_IDX) |=> readdata == $past(lock_r)
    && $stable(lock_r))
    else $error("lock read wrong or disturbed state");
  flag_read_a: assert property (@(posedge ref_clk) disable iff (srst)
    (read && address == hwmtx_pkg::RESET_INDICATOR_IDX) |=> readdata[31:1] == 31'h0
    && readdata[0] == $past(reset_flag_r))
    else $error("reset flag read wrong");
  flag_sticky_a: assert property (@(posedge ref_clk) disable iff (srst)
    !reset_flag_r |=> !reset_flag_r)
    else $error("reset flag set again without reset");
  flag_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    (write && address == hwmtx_pkg::RESET_INDICATOR_IDX && writedata[0]) |=> !reset_flag_r)
    else $error("reset flag not cleared by write of one");
  flag_reset_a: assert property (@(posedge ref_clk) srst |=> reset_flag_r &&
    lock_r.value == INIT_VALUE && lock_r.owner == INIT_OWNER)
    else $error("reset values not loaded");
  held_out_a: assert property (@(posedge ref_clk) disable iff (srst)
    lock_held == (lock_r.value != 16'h0000))
    else $error("lock held output disagrees with value");

  // ----------------------------------------------------------------
  // Checks: lock register isolation and field layout
  // ----------------------------------------------------------------
  // Each register must be untouched by traffic aimed at the other word
  lock_write_flag_a: assert property (@(posedge ref_clk) disable iff (srst)
    (write && address == hwmtx_pkg::RESET_INDICATOR_IDX)
    |=> $stable(lock_r))
    else $error("flag register write disturbed the lock");

  flag_write_lock_a: assert property (@(posedge ref_clk) disable iff (srst)
    (write && address == hwmtx_pkg::LOCK_STATE_IDX)
    |=> $stable(reset_flag_r))
    else $error("lock register write disturbed the flag");

  owner_field_a: assert property (@(posedge ref_clk) disable iff (srst)
    (read && address == hwmtx_pkg::LOCK_STATE_IDX)
    |=> readdata[31:16] == $past(lock_r.owner))
    else $error("holder field read from wrong bits");

  value_field_a: assert property (@(posedge ref_clk) disable iff (srst)
    (read && address == hwmtx_pkg::LOCK_STATE_IDX)
    |=> readdata[15:0] == $past(lock_r.value))
    else $error("lock value field read from wrong bits");

  held_track_a: assert property (@(posedge ref_clk) disable iff (srst)
    (write && address == hwmtx_pkg::LOCK_STATE_IDX && is_free(lock_r) &&
     writedata[15:0] != hwmtx_pkg::VALUE_FREE)
    |=> lock_held)
    else $error("lock held not raised on acquire");

  read_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    !read
    |=> $stable(readdata))
    else $error("read data changed without a read");

  read_pure_a: assert property (@(posedge ref_clk) disable iff (srst)
    (read && !write)
    |=> $stable(reset_flag_r))
    else $error("read disturbed the reset flag");

  idle_lock_a: assert property (@(posedge ref_clk) disable iff (srst)
    !write
    |=> $stable(lock_r))
    else $error("lock changed without a write");

  refused_held_a: assert property (@(posedge ref_clk) disable iff (srst)
    (write && address == hwmtx_pkg::LOCK_STATE_IDX && !is_free(lock_r) &&
     lock_r.owner != writedata[31:16])
    |=> $stable(lock_held))
    else $error("refused write moved the held status");

  release_free_a: assert property (@(posedge ref_clk) disable iff (srst)
    (write && address == hwmtx_pkg::LOCK_STATE_IDX && lock_r.owner == writedata[31:16] &&
     writedata[15:0] == hwmtx_pkg::VALUE_FREE)
    |=> !lock_held)
    else $error("release by holder left lock held");

  // Two contenders back to back: the first taker must keep the lock
  bus_order_a: assert property (@(posedge ref_clk) disable iff (srst)
    (write && address == hwmtx_pkg::LOCK_STATE_IDX && is_free(lock_r) &&
     writedata[15:0] != hwmtx_pkg::VALUE_FREE) ##1
    (write && address == hwmtx_pkg::LOCK_STATE_IDX &&
     writedata[31:16] != $past(writedata[31:16]))
    |=> lock_r == $past(writedata, 2))
    else $error("back to back writes not resolved in bus order");

  // ----------------------------------------------------------------
  // Checks: reset flag and reset values
  // ----------------------------------------------------------------
  flag_ignore_a: assert property (@(posedge ref_clk) disable iff (srst)
    (write && address == hwmtx_pkg::RESET_INDICATOR_IDX && !writedata[0])
    |=> $stable(reset_flag_r))
    else $error("flag write without bit zero had an effect");

  flag_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    (reset_flag_r && !(write && address == hwmtx_pkg::RESET_INDICATOR_IDX && writedata[0]))
    |=> reset_flag_r)
    else $error("reset flag dropped without a clearing write");

  // Reset clears the read data register, so the read port starts from a known word
  reset_read_a: assert property (@(posedge ref_clk)
    srst
    |=> readdata == hwmtx_pkg::READ_ZERO)
    else $error("read data not cleared by reset");

  reset_held_a: assert property (@(posedge ref_clk)
    srst
    |=> lock_held == (INIT_VALUE != hwmtx_pkg::VALUE_FREE))
    else $error("lock held status wrong after reset");

endmodule // hwmtx_core

`default_nettype wire

/* tb/hwmtx_core_tb_top.sv */
// Testbench for the hardware lock
`timescale 1ns/1ps
`default_nettype none
module hwmtx_core_tb_top;
  logic ref_clk = 1'h0;
  logic srst = 1'h1;
  logic [31:0] readdata;
  logic lock_held;
  logic [31:0] d;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  hwmtx_pkg::hwmtx_req_type req;
  initial forever #50 ref_clk = ~ref_clk;
  hwmtx_core #(.INIT_VALUE(16'h0005), .INIT_OWNER(16'h00A1)) hwmtx_core_i (.ref_clk(ref_clk),
    .srst(srst), .address(req.address), .read(req.read), .write(req.write),
    .writedata(req.writedata), .readdata(readdata), .lock_held(lock_held));
  hwmtx_cpu_model hwmtx_cpu_model_i (.ref_clk(ref_clk), .req(req), .readdata(readdata));
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic rc(input logic [0:0] a, input logic [31:0] exp, input string s);
    hwmtx_cpu_model_i.get(a, d);
    chk(s, d, exp);
  endtask
  task automatic wr(input logic [0:0] a, input logic [31:0] v, input bit h);
    hwmtx_cpu_model_i.put(a, v, h);
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    srst <= 1'h1;
    repeat (6) @(posedge ref_clk);
    srst <= 1'h0;
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard: whole run needs well under a hundred cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic t_init();
    rc(1'h0, 32'h00A1_0005, "lock");
    chk("held", {31'h0, lock_held}, 32'h1);
    rc(1'h1, 32'h0000_0001, "flag");
  endtask
  task automatic t_refuse();
    wr(1'h0, 32'h00B2_0007, 1'b0);
    rc(1'h0, 32'h00A1_0005, "refused");
    rc(1'h0, 32'h00A1_0005, "reread");
  endtask
  task automatic t_order();
    wr(1'h0, 32'h00A1_0000, 1'b0);
    rc(1'h0, 32'h00A1_0000, "release");
    chk("free", {31'h0, lock_held}, 32'h0);
    wr(1'h0, 32'h00C3_0001, 1'b1);
    wr(1'h0, 32'h00D4_0002, 1'b0);
    rc(1'h0, 32'h00C3_0001, "order");
    wr(1'h0, 32'h00C3_0009, 1'b0);
    rc(1'h0, 32'h00C3_0009, "rewrite");
  endtask
  task automatic t_flag();
    wr(1'h1, 32'hFFFF_FFFE, 1'b0);
    rc(1'h1, 32'h0000_0001, "reserved");
    wr(1'h1, 32'h0000_0001, 1'b0);
    rc(1'h1, 32'h0000_0000, "clear");
    rc(1'h0, 32'h00C3_0009, "kept");
    do_reset();
    rc(1'h1, 32'h0000_0001, "reflag");
    rc(1'h0, 32'h00A1_0005, "relock");
  endtask
  initial begin
    do_reset();
    t_init();
    t_refuse();
    t_order();
    t_flag();
    give_verdict();
  end
endmodule // hwmtx_core_tb_top
`default_nettype wire

/* tb/hwmtx_cpu_model.sv */
// Processor model driving word accesses on the lock agent port
`timescale 1ns/1ps
`default_nettype none
module hwmtx_cpu_model (
  // Clock
  input wire logic ref_clk,
  // Agent port
  output var hwmtx_pkg::hwmtx_req_type req,
  input wire logic [31:0] readdata
);
  bit held = 1'b0;
  initial req = '0;
  // Caller puts its own id in holder field; strobe may stay up for back-to-back writes
  task automatic put(input logic [0:0] a, input logic [31:0] v, input bit h);
    if (!held)
      @(posedge ref_clk);
    req.write <= 1'h1;
    req.address <= a;
    req.writedata <= v;
    @(posedge ref_clk);
    held = h;
    if (!h) begin
      req.write <= 1'h0;
      req.writedata <= ~v;
    end
  endtask
  // Released lines show the inverse, so stale data cannot pass for an answer
  task automatic get(input logic [0:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    req.read <= 1'h1;
    req.address <= a;
    @(posedge ref_clk);
    req.read <= 1'h0;
    req.address <= ~a;
    #1 v = readdata;
  endtask
endmodule // hwmtx_cpu_model
`default_nettype wire
